/* File: src/tq_timer_top.sv */
// Six-channel 16-bit timer with quadrature decoder and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
// ---------------------------------------------------------------
// ---------------------------------------------------------------
module tq_timer_top (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	// AXI4-Lite write address and data
	input wire logic S_AXI_AWVALID_IN,
	output logic S_AXI_AWREADY_OUT,
	input wire logic [11:0] S_AXI_AWADDR_IN,
	input wire logic S_AXI_WVALID_IN,
	output logic S_AXI_WREADY_OUT,
	input wire logic [31:0] S_AXI_WDATA_IN,
	input wire logic [3:0] S_AXI_WSTRB_IN,
	// AXI4-Lite write response
	output logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	output logic [1:0] S_AXI_BRESP_OUT,
	// AXI4-Lite read
	input wire logic S_AXI_ARVALID_IN,
	output logic S_AXI_ARREADY_OUT,
	input wire logic [11:0] S_AXI_ARADDR_IN,
	output logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	output logic [31:0] S_AXI_RDATA_OUT,
	output logic [1:0] S_AXI_RRESP_OUT,
	// Pins and external clock
	input wire logic [5:0] CHAN_CLOCK_CAPTURE_PIN_IN,
	input wire logic EXT_TIMER_CLOCK_IN,
	output wire logic [5:0] CHAN_OUTPUT_PIN_OUT,
	// Per-channel converter trigger and interrupt
	output wire logic [5:0] CONV_TRIGGER_OUT,
	output wire logic [5:0] CHAN_IRQ_OUT
);
	localparam int N = tq_pkg::NUM_CH;

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] wmerge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// Address to channel number, group register or nothing
	function automatic logic [2:0] addr_dec(input logic [11:0] a);
		logic [3:0] w;
		w = a[8:5];
		if (a[11:9] != 3'h0) begin
			addr_dec = tq_pkg::DEC_NONE;
		end else if (w < 4'(tq_pkg::QD_CH)) begin
			addr_dec = w[2:0];
		end else if (w == tq_pkg::CH_HI_BASE[8:5]) begin
			addr_dec = tq_pkg::CH_HI_FIRST;
		end else if (w == 4'(tq_pkg::CH_HI_BASE[8:5] + tq_pkg::CH_STRIDE[8:5])) begin
			addr_dec = tq_pkg::CH_HI_FIRST + 3'h1;
		end else if (a[8:2] == tq_pkg::GECR_OFS[8:2]) begin
			addr_dec = tq_pkg::DEC_GECR;
		end else begin
			addr_dec = tq_pkg::DEC_NONE;
		end
	endfunction

	// Edge pick: 00 rising, 01 falling, 1x both
	function automatic logic edge_pick(input logic [1:0] sel, input logic r, input logic f);
		edge_pick = sel[1] ? (r | f) : (sel[0] ? f : r);
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers and clock dividers
	// ---------------------------------------------------------------
	logic [5:0] pin_s1_r, pin_s2_r, pin_s3_r;
	logic ext_s1_r, ext_s2_r, ext_s3_r;
	logic [5:0] div_cnt_r;
	logic [5:0] pin_rise, pin_fall;
	logic ext_rise;
	logic [3:0] div_tick;

	// Two flops before use; third flop only keeps the previous level
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			pin_s1_r <= 6'h00;
			pin_s2_r <= 6'h00;
			pin_s3_r <= 6'h00;
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
			ext_s3_r <= 1'b0;
		end else begin
			pin_s1_r <= CHAN_CLOCK_CAPTURE_PIN_IN;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			ext_s1_r <= EXT_TIMER_CLOCK_IN;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end

	// Free-running divider shared by every channel
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			div_cnt_r <= 6'h00;
		end else begin
			div_cnt_r <= div_cnt_r + 6'h01;
		end
	end

	assign pin_rise = pin_s2_r & ~pin_s3_r;
	assign pin_fall = ~pin_s2_r & pin_s3_r;
	assign ext_rise = ext_s2_r & ~ext_s3_r;
	assign div_tick[0] = &div_cnt_r[tq_pkg::DIV_SH0-1:0];
	assign div_tick[1] = &div_cnt_r[tq_pkg::DIV_SH1-1:0];
	assign div_tick[2] = &div_cnt_r[tq_pkg::DIV_SH2-1:0];
	assign div_tick[3] = &div_cnt_r[tq_pkg::DIV_SH3-1:0];

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	logic wr_fire, rd_fire;
	logic [2:0] wr_dec, rd_dec;
	logic [4:0] wr_ofs;
	logic [15:0] rd_word [N];
	logic [15:0] rd_sel;
	tq_pkg::tq_gecr_s gecr_r;

	assign wr_dec = addr_dec(S_AXI_AWADDR_IN);
	assign rd_dec = addr_dec(S_AXI_ARADDR_IN);
	assign wr_ofs = S_AXI_AWADDR_IN[4:0];
	// Ready flops high only in the handshake cycle
	assign wr_fire = S_AXI_AWREADY_OUT;
	assign rd_fire = S_AXI_ARREADY_OUT;

	// Write path: take address and data together, answer one cycle later
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			S_AXI_AWREADY_OUT <= 1'b0;
			S_AXI_WREADY_OUT <= 1'b0;
			S_AXI_BVALID_OUT <= 1'b0;
			S_AXI_BRESP_OUT <= tq_pkg::RESP_OKAY;
		end else begin
			S_AXI_AWREADY_OUT <= S_AXI_AWVALID_IN && S_AXI_WVALID_IN
				&& !S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
			S_AXI_WREADY_OUT <= S_AXI_AWVALID_IN && S_AXI_WVALID_IN
				&& !S_AXI_AWREADY_OUT && !S_AXI_BVALID_OUT;
			if (wr_fire) begin
				S_AXI_BVALID_OUT <= 1'b1;
				S_AXI_BRESP_OUT <= (wr_dec == tq_pkg::DEC_NONE) ? tq_pkg::RESP_SLVERR : tq_pkg::RESP_OKAY;
			end else if (S_AXI_BREADY_IN) begin
				S_AXI_BVALID_OUT <= 1'b0;
			end
		end
	end

	// Read data mux; reads have no side effects
	always_comb begin
		rd_sel = 16'h0000;
		if (rd_dec < tq_pkg::CH_HI_FIRST + 3'h2) begin
			rd_sel = rd_word[rd_dec];
		end else if (rd_dec == tq_pkg::DEC_GECR) begin
			rd_sel = gecr_r;
		end
	end

	// Read path
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			S_AXI_ARREADY_OUT <= 1'b0;
			S_AXI_RVALID_OUT <= 1'b0;
			S_AXI_RDATA_OUT <= 32'h0000_0000;
			S_AXI_RRESP_OUT <= tq_pkg::RESP_OKAY;
		end else begin
			S_AXI_ARREADY_OUT <= S_AXI_ARVALID_IN && !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT;
			if (rd_fire) begin
				S_AXI_RVALID_OUT <= 1'b1;
				S_AXI_RDATA_OUT <= {16'h0000, rd_sel};
				S_AXI_RRESP_OUT <= (rd_dec == tq_pkg::DEC_NONE) ? tq_pkg::RESP_SLVERR : tq_pkg::RESP_OKAY;
			end else if (S_AXI_RREADY_IN) begin
				S_AXI_RVALID_OUT <= 1'b0;
			end
		end
	end

	// Group encoder control register
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			gecr_r <= tq_pkg::REG_RESET;
		end else if (wr_fire && wr_dec == tq_pkg::DEC_GECR) begin
			gecr_r <= wmerge(gecr_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN) & tq_pkg::GECR_MASK;
		end
	end

	// ---------------------------------------------------------------
	// Quadrature decoder, shared by channels 0 to 3
	// ---------------------------------------------------------------
	logic qd_en, qa, qb, qa_p, qb_p, qz, qz_p;
	logic a_any, b_any, a_cnt, b_cnt, z_ev;
	logic dir_r, dir_nxt;
	logic [N-1:0] q_ev, qd_on, dir_ctl;

	assign qd_en = gecr_r.quad_decoder_en;
	// Swap exchanges the two phase inputs
	assign qa = gecr_r.phase_swap ? pin_s2_r[1] : pin_s2_r[0];
	assign qb = gecr_r.phase_swap ? pin_s2_r[0] : pin_s2_r[1];
	assign qa_p = gecr_r.phase_swap ? pin_s3_r[1] : pin_s3_r[0];
	assign qb_p = gecr_r.phase_swap ? pin_s3_r[0] : pin_s3_r[1];
	assign qz = pin_s2_r[2];
	assign qz_p = pin_s3_r[2];
	assign a_any = qa ^ qa_p;
	assign b_any = qb ^ qb_p;
	assign a_cnt = edge_pick(gecr_r.pha_edge_sel, qa & ~qa_p, ~qa & qa_p);
	assign b_cnt = edge_pick(gecr_r.phb_edge_sel, qb & ~qb_p, ~qb & qb_p);
	assign z_ev = gecr_r.index_edge_sel ? (~qz & qz_p) : (qz & ~qz_p);

	// A edge with phases unequal means A leads; same test inverted for B
	always_comb begin
		dir_nxt = dir_r;
		if (a_any) begin
			dir_nxt = ~(qa ^ qb);
		end else if (b_any) begin
			dir_nxt = qa ^ qb;
		end
	end

	// Direction state
	always_ff @(posedge CORE_CLK_IN) begin
		if (RST_IN) begin
			dir_r <= 1'b0;
		end else if (qd_en) begin
			dir_r <= dir_nxt;
		end
	end

	// Count events: phase A, phase B, position, revolution
	assign q_ev = {2'b00, z_ev, a_cnt | b_cnt, b_cnt, a_cnt} & {N{qd_en}};
	assign qd_on = {2'b00, {tq_pkg::QD_CH{qd_en}}};
	assign dir_ctl = {2'b00, gecr_r[11:8]};

	// ---------------------------------------------------------------
	// Timer channels
	// ---------------------------------------------------------------
	generate
		for (genvar g = 0; g < N; g++) begin : ch
			tq_pkg::tq_cr1_s cr1_r;
			logic run_r, out_r, trig_r, irq_r;
			logic [9:0] prs_r, pre_r;
			logic [15:0] gra_r, grb_r, cnt_r, ier_r, sr_r, sr_view, wd;
			logic [1:0] trig_cnt_r;
			logic [tq_pkg::CAPT_STAGES-1:0] crise_r, cfall_r;
			logic hit, src, tick, clr_cmd, step, hit_a, hit_b, wrap, down;
			logic cap_take, cap_r, cap_f, pwm_like, capmode, idx_clr;
			logic [15:0] cnt_inc, period, sr_set, prs_w;

			assign hit = wr_fire && wr_dec == 3'(g);
			assign wd = wmerge(16'h0000, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
			assign clr_cmd = hit && wr_ofs == tq_pkg::OFS_CR2 && wd[tq_pkg::CR2_CLR];
			assign capmode = cr1_r.mode == tq_pkg::MODE_CAPTURE;
			assign pwm_like = cr1_r.mode == tq_pkg::MODE_PWM || cr1_r.mode == tq_pkg::MODE_ONESHOT;
			// Prescale write merged at full width, then cut to the 10-bit field
			assign prs_w = wmerge({6'h00, prs_r}, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);

			// Clock source select
			always_comb begin
				case (cr1_r.count_clk_source[2:1])
					2'b00: src = cr1_r.count_clk_source[0] ? div_tick[1] : div_tick[0];
					2'b01: src = cr1_r.count_clk_source[0] ? div_tick[3] : div_tick[2];
					2'b10: src = ext_rise;
					default: src = pin_rise[g];
				endcase
			end

			// Count step, matches and wrap
			always_comb begin
				tick = src && pre_r == prs_r;
				cnt_inc = cnt_r + 16'h0001;
				period = pwm_like ? grb_r : gra_r;
				step = run_r && (qd_on[g] ? q_ev[g] : (tick && (capmode || period != 16'h0000)));
				down = qd_on[g] && dir_ctl[g] && dir_r;
				hit_a = step && !capmode && !qd_on[g] && cnt_inc == gra_r;
				hit_b = step && pwm_like && !qd_on[g] && cnt_inc == grb_r;
				wrap = step && !down && cnt_r == 16'hffff;
				idx_clr = qd_on[g] && g == 2 && q_ev[3];
			end

			// Capture edges land five cycles after the pin edge
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					crise_r <= '0;
					cfall_r <= '0;
				end else begin
					crise_r <= {crise_r[tq_pkg::CAPT_STAGES-2:0], pin_rise[g]};
					cfall_r <= {cfall_r[tq_pkg::CAPT_STAGES-2:0], pin_fall[g]};
				end
			end
			assign cap_r = crise_r[tq_pkg::CAPT_STAGES-1];
			assign cap_f = cfall_r[tq_pkg::CAPT_STAGES-1];
			// Clear mode 11 neither captures nor clears
			assign cap_take = capmode && !qd_on[g] && run_r && (
				(cr1_r.capture_clear_sel == 2'b00 && cap_r)
				|| (cr1_r.capture_clear_sel == 2'b01 && cap_f)
				|| (cr1_r.capture_clear_sel == 2'b10 && (cap_r || cap_f)));

			// Configuration registers
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					cr1_r <= tq_pkg::REG_RESET;
					prs_r <= 10'h000;
					ier_r <= tq_pkg::REG_RESET;
				end else if (hit) begin
					if (wr_ofs == tq_pkg::OFS_CR1) cr1_r <= wmerge(cr1_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN) & tq_pkg::CR1_MASK;
					if (wr_ofs == tq_pkg::OFS_PRS) prs_r <= prs_w[9:0];
					if (wr_ofs == tq_pkg::OFS_IER) ier_r <= wmerge(ier_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN) & tq_pkg::IER_MASK;
				end
			end

			// Run enable; one-shot stops itself at the end of the pulse
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					run_r <= 1'b0;
				end else if (hit && wr_ofs == tq_pkg::OFS_CR2 && S_AXI_WSTRB_IN[0]) begin
					run_r <= S_AXI_WDATA_IN[tq_pkg::CR2_RUN];
				end else if (hit_b && cr1_r.mode == tq_pkg::MODE_ONESHOT) begin
					run_r <= 1'b0;
				end
			end

			// Prescaler
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN || clr_cmd) begin
					pre_r <= 10'h000;
				end else if (src && run_r) begin
					pre_r <= (pre_r == prs_r) ? 10'h000 : pre_r + 10'h001;
				end
			end

			// Counter: clear, load, capture clear, then counting
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN || clr_cmd) begin
					cnt_r <= 16'h0000;
				end else if (hit && wr_ofs == tq_pkg::OFS_CNT) begin
					cnt_r <= wmerge(cnt_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
				end else if (cap_take || idx_clr) begin
					cnt_r <= 16'h0000;
				end else if (step) begin
					if (down) begin
						cnt_r <= cnt_r - 16'h0001;
					end else if (hit_b || (hit_a && cr1_r.mode == tq_pkg::MODE_PERIODIC)) begin
						cnt_r <= 16'h0000;
					end else begin
						cnt_r <= cnt_inc;
					end
				end
			end

			// General registers; capture shifts the previous value into B
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					gra_r <= tq_pkg::REG_RESET;
					grb_r <= tq_pkg::REG_RESET;
				end else if (hit && wr_ofs == tq_pkg::OFS_GRA) begin
					gra_r <= wmerge(gra_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
				end else if (hit && wr_ofs == tq_pkg::OFS_GRB) begin
					grb_r <= wmerge(grb_r, S_AXI_WDATA_IN, S_AXI_WSTRB_IN);
				end else if (cap_take) begin
					gra_r <= cnt_r;
					grb_r <= gra_r;
				end else if (idx_clr) begin
					grb_r <= cnt_r;
				end
			end

			// Output pin: start level, toggle on A in periodic mode
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					out_r <= 1'b0;
				end else if (clr_cmd) begin
					out_r <= cr1_r.initial_out_level;
				end else if (hit_b) begin
					out_r <= cr1_r.initial_out_level;
				end else if (hit_a) begin
					out_r <= pwm_like ? ~cr1_r.initial_out_level : ~out_r;
				end
			end

			// Status flags: a set in the clearing cycle wins
			always_comb begin
				sr_set = 16'h0000;
				sr_set[tq_pkg::SR_OVF] = wrap;
				sr_set[tq_pkg::SR_MFB] = hit_b;
				sr_set[tq_pkg::SR_MFA] = hit_a || cap_take;
				sr_set[tq_pkg::SR_REV] = qd_on[g] && q_ev[3];
				sr_set[tq_pkg::SR_DCH] = qd_on[g] && dir_nxt != dir_r;
			end
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					sr_r <= tq_pkg::REG_RESET;
				end else if (hit && wr_ofs == tq_pkg::OFS_SR) begin
					sr_r <= ((sr_r & ~wd) | sr_set) & tq_pkg::SR_FLAG_MASK;
				end else begin
					sr_r <= (sr_r | sr_set) & tq_pkg::SR_FLAG_MASK;
				end
			end
			always_comb begin
				sr_view = sr_r;
				sr_view[tq_pkg::SR_DIR] = qd_on[g] && dir_r;
			end

			// Interrupt and converter trigger of three cycles
			always_ff @(posedge CORE_CLK_IN) begin
				if (RST_IN) begin
					irq_r <= 1'b0;
					trig_r <= 1'b0;
					trig_cnt_r <= 2'h0;
				end else begin
					irq_r <= |(sr_r & ier_r);
					if (hit_a && cr1_r.conv_trigger_en) begin
						trig_cnt_r <= tq_pkg::TRIG_CYCLES;
						trig_r <= 1'b1;
					end else if (trig_cnt_r > 2'h1) begin
						trig_cnt_r <= trig_cnt_r - 2'h1;
						trig_r <= 1'b1;
					end else begin
						trig_cnt_r <= 2'h0;
						trig_r <= 1'b0;
					end
				end
			end

			// Readback; clear bit is write-only and reads zero
			always_comb begin
				case ({S_AXI_ARADDR_IN[4:2], 2'b00})
					tq_pkg::OFS_CR1: rd_word[g] = cr1_r;
					tq_pkg::OFS_CR2: rd_word[g] = {15'h0000, run_r};
					tq_pkg::OFS_PRS: rd_word[g] = {6'h00, prs_r};
					tq_pkg::OFS_GRA: rd_word[g] = gra_r;
					tq_pkg::OFS_GRB: rd_word[g] = grb_r;
					tq_pkg::OFS_CNT: rd_word[g] = cnt_r;
					tq_pkg::OFS_SR: rd_word[g] = sr_view;
					default: rd_word[g] = ier_r;
				endcase
			end

			assign CHAN_OUTPUT_PIN_OUT[g] = out_r;
			assign CONV_TRIGGER_OUT[g] = trig_r;
			assign CHAN_IRQ_OUT[g] = irq_r;
		end
	endgenerate
endmodule

/* File: shared/tq_pkg.sv */
// Constants, field layouts and types shared by the six-channel timer
package tq_pkg;
	// ---------------------------------------------------------------
	// Channel bank and address map
	// ---------------------------------------------------------------
	localparam int NUM_CH = 6;
	localparam int QD_CH = 4;
	localparam logic [11:0] CH_STRIDE = 12'h020;
	localparam logic [11:0] CH_HI_BASE = 12'h100;
	localparam logic [11:0] GECR_OFS = 12'h140;
	localparam logic [2:0] CH_HI_FIRST = 3'h4;
	localparam logic [2:0] DEC_GECR = 3'h6;
	localparam logic [2:0] DEC_NONE = 3'h7;
	// Byte offsets inside one channel window
	localparam logic [4:0] OFS_CR1 = 5'h00;
	localparam logic [4:0] OFS_CR2 = 5'h04;
	localparam logic [4:0] OFS_PRS = 5'h08;
	localparam logic [4:0] OFS_GRA = 5'h0c;
	localparam logic [4:0] OFS_GRB = 5'h10;
	localparam logic [4:0] OFS_CNT = 5'h14;
	localparam logic [4:0] OFS_SR = 5'h18;
	localparam logic [4:0] OFS_IER = 5'h1c;
	// ---------------------------------------------------------------
	// Field positions, masks and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] CR1_MASK = 16'h01ff;
	localparam logic [15:0] SR_FLAG_MASK = 16'h0307;
	localparam logic [15:0] IER_MASK = 16'h0307;
	localparam logic [15:0] GECR_MASK = 16'h0ffd;
	localparam int CR2_RUN = 0;
	localparam int CR2_CLR = 1;
	localparam int SR_OVF = 0;
	localparam int SR_MFB = 1;
	localparam int SR_MFA = 2;
	localparam int SR_REV = 8;
	localparam int SR_DCH = 9;
	localparam int SR_DIR = 10;
	// ---------------------------------------------------------------
	// Cycle counts and bus answers
	// ---------------------------------------------------------------
	localparam int DIV_SH0 = 1;
	localparam int DIV_SH1 = 2;
	localparam int DIV_SH2 = 4;
	localparam int DIV_SH3 = 6;
	localparam int CAPT_STAGES = 3;
	localparam logic [1:0] TRIG_CYCLES = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_PERIODIC = 2'h0,
		MODE_PWM = 2'h1,
		MODE_ONESHOT = 2'h2,
		MODE_CAPTURE = 2'h3
	} tq_mode_e;
	typedef struct packed {
		logic [6:0] rsvd;
		logic conv_trigger_en;
		logic initial_out_level;
		logic [2:0] count_clk_source;
		logic [1:0] capture_clear_sel;
		tq_mode_e mode;
	} tq_cr1_s;
	typedef struct packed {
		logic [3:0] rsvd;
		logic rev_counter_dir_ctl;
		logic pos_counter_dir_ctl;
		logic phb_counter_dir_ctl;
		logic pha_counter_dir_ctl;
		logic [1:0] phb_edge_sel;
		logic [1:0] pha_edge_sel;
		logic index_edge_sel;
		logic phase_swap;
		logic rsvd1;
		logic quad_decoder_en;
	} tq_gecr_s;
endpackage

/* File: bench/tq_timer_properties.sv */
// Bus, trigger and reset checks on the timer top ports
`timescale 1ns/1ns
module tq_timer_properties (
	// Clock and reset
	input wire logic CORE_CLK_IN,
	input wire logic RST_IN,
	// Bus handshakes
	input wire logic S_AXI_AWREADY_OUT,
	input wire logic S_AXI_BVALID_OUT,
	input wire logic S_AXI_BREADY_IN,
	input wire logic S_AXI_ARREADY_OUT,
	input wire logic [11:0] S_AXI_ARADDR_IN,
	input wire logic S_AXI_RVALID_OUT,
	input wire logic S_AXI_RREADY_IN,
	input wire logic [31:0] S_AXI_RDATA_OUT,
	input wire logic [1:0] S_AXI_RRESP_OUT,
	// Channel outputs
	input wire logic [5:0] CONV_TRIGGER_OUT,
	input wire logic [5:0] CHAN_IRQ_OUT
);
	// ----
	// Properties
	// ----
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (RST_IN);
	chk_trig_three: assert property ($rose(CONV_TRIGGER_OUT[0]) |-> CONV_TRIGGER_OUT[0] [*3] ##1 !CONV_TRIGGER_OUT[0])
		else $error("trigger width wrong");
	chk_write_resp: assert property (S_AXI_AWREADY_OUT |=> S_AXI_BVALID_OUT && !S_AXI_AWREADY_OUT)
		else $error("no write response");
	chk_read_resp: assert property (S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
		else $error("no read response");
	chk_bvalid_drop: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=> !S_AXI_BVALID_OUT)
		else $error("write response stuck");
	chk_rvalid_drop: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=> !S_AXI_RVALID_OUT)
		else $error("read response stuck");
	chk_unmapped_err: assert property (S_AXI_ARREADY_OUT && S_AXI_ARADDR_IN[11:9] != 3'h0 |=>
		S_AXI_RRESP_OUT == tq_pkg::RESP_SLVERR && S_AXI_RDATA_OUT == 32'h0000_0000)
		else $error("unmapped read not refused");
	chk_upper_zero: assert property (S_AXI_RVALID_OUT |-> S_AXI_RDATA_OUT[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_reset_quiet: assert property ($fell(RST_IN) |-> CHAN_IRQ_OUT == 6'h00 && CONV_TRIGGER_OUT == 6'h00)
		else $error("outputs active after reset");
	// Main scenarios reached
	cover property ($rose(CONV_TRIGGER_OUT[0]));
	cover property ($rose(CHAN_IRQ_OUT[0]));
	cover property (S_AXI_RVALID_OUT && S_AXI_RRESP_OUT == tq_pkg::RESP_SLVERR);
endmodule
bind tq_timer_top tq_timer_properties chk (.CORE_CLK_IN, .RST_IN, .S_AXI_AWREADY_OUT, .S_AXI_BVALID_OUT,
	.S_AXI_BREADY_IN, .S_AXI_ARREADY_OUT, .S_AXI_ARADDR_IN, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN,
	.S_AXI_RDATA_OUT, .S_AXI_RRESP_OUT, .CONV_TRIGGER_OUT, .CHAN_IRQ_OUT);

/* File: bench/tq_pin_model.sv */
// Encoder and capture-signal source facing the timer pins
`timescale 1ns/1ns
module tq_pin_model (
	// Driven pins
	output logic [5:0] pins_out,
	output logic ext_clk_out
);
	// ----
	// Edge generation
	// ----
	initial begin
		pins_out = 6'h00;
		ext_clk_out = 1'b0;
	end
	// Offset from the bus clock so the sync flops never race the edge
	task pulse(input int ch);
		#17;
		pins_out[ch] = 1'b1;
		#1000;
		pins_out[ch] = 1'b0;
		#1000;
	endtask
	// One full quadrature cycle; fwd means phase A leads
	task quad(input logic fwd);
		int k;
		for (k = 0; k < 4; k++) begin
			#517;
			if (fwd ^ k[0]) pins_out[0] = ~pins_out[0];
			else pins_out[1] = ~pins_out[1];
		end
	endtask
endmodule

/* File: bench/tb_top.sv */
// Register-level test sequence for the six-channel timer
`timescale 1ns/1ns
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
	logic [11:0] aw = 12'h000, ar = 12'h000;
	logic [31:0] wd = 32'h0000_0000, rd_d, rdata;
	logic [1:0] rd_r, bresp, rresp;
	logic awr, wrdy, bv, arr, rv, ext;
	logic [5:0] pins, cout, trig, irq;
	int fail_count = 0, n_tests = 0, i, m;
	// 10 MHz bus clock
	always #50 clk = ~clk;
	tq_pin_model pm (.pins_out(pins), .ext_clk_out(ext));
	tq_timer_top dut (.CORE_CLK_IN(clk), .RST_IN(rst), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
		.S_AXI_AWADDR_IN(aw), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy), .S_AXI_WDATA_IN(wd),
		.S_AXI_WSTRB_IN(4'hf), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
		.S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ar), .S_AXI_RVALID_OUT(rv),
		.S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
		.CHAN_CLOCK_CAPTURE_PIN_IN(pins), .EXT_TIMER_CLOCK_IN(ext), .CHAN_OUTPUT_PIN_OUT(cout),
		.CONV_TRIGGER_OUT(trig), .CHAN_IRQ_OUT(irq));
	// ----
	// Tasks
	// ----
	task test_done;
		$display("Checks %0d, errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// A wait that ran out ends the run
	task hang(input int k);
		if (k >= 200) begin
			fail_count++;
			$display("Error wait: expected below 200, seen %0d", k);
			test_done;
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		awv <= 1'b1;
		wv <= 1'b1;
		aw <= a;
		wd <= d;
		br <= 1'b1;
		for (k = 0; k < 200 && !bv; k++) begin
			@(posedge clk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end
		br <= 1'b0;
		hang(k);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge clk);
		arv <= 1'b1;
		ar <= a;
		rr <= 1'b1;
		for (k = 0; k < 200 && !rv; k++) begin
			@(posedge clk);
			if (arr) arv <= 1'b0;
		end
		d = rdata;
		r = rresp;
		rr <= 1'b0;
		hang(k);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		rd(a, rd_d, rd_r);
		chk(nm, e, rd_d);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 32; i += 4) rc(i[11:0], 32'h0000_0000, "reset value");
		rc(12'h140, 32'h0000_0000, "group reset");
		wr(12'h024, 32'h0000_00ff);
		rc(12'h024, 32'h0000_0001, "control two");
		// Running with a zero period must not move the loaded count
		wr(12'h034, 32'h0000_1234);
		rc(12'h034, 32'h0000_1234, "count load");
		wr(12'h024, 32'h0000_0002);
		rc(12'h034, 32'h0000_0000, "count clear");
		wr(12'h10c, 32'h0000_abcd);
		rc(12'h10c, 32'h0000_abcd, "high bank");
		rc(12'h00c, 32'h0000_0000, "low bank");
		rd(12'h200, rd_d, rd_r);
		chk("unmapped", tq_pkg::RESP_SLVERR, rd_r);
		wr(12'h200, 32'h0000_ffff);
		chk("write refused", tq_pkg::RESP_SLVERR, bresp);
		wr(12'h000, 32'h0000_0081);
		wr(12'h004, 32'h0000_0002);
		chk("start level", 32'h0000_0001, cout[0]);
		// Periodic channel 0 with trigger and match A interrupt
		wr(12'h00c, 32'h0000_0004);
		wr(12'h01c, 32'h0000_0004);
		wr(12'h000, 32'h0000_0100);
		wr(12'h004, 32'h0000_0003);
		for (i = 0; i < 200 && !irq[0]; i++) @(posedge clk);
		hang(i);
		for (i = 0; i < 200 && !trig[0]; i++) @(posedge clk);
		hang(i);
		wr(12'h004, 32'h0000_0000);
		rc(12'h018, 32'h0000_0004, "match a only");
		wr(12'h018, 32'h0000_0004);
		rc(12'h018, 32'h0000_0000, "flag clear");
		chk("irq drop", 32'h0000_0000, irq[0]);
		// Free count from near the top wraps into overflow
		wr(12'h034, 32'h0000_fffe);
		wr(12'h020, 32'h0000_000f);
		wr(12'h024, 32'h0000_0001);
		repeat (10) @(posedge clk);
		wr(12'h024, 32'h0000_0000);
		rc(12'h038, 32'h0000_0001, "overflow");
		// Each capture clear mode against one full pulse
		for (m = 0; m < 4; m++) begin
			wr(12'h020, {28'h000_0000, m[1:0], 2'h3});
			wr(12'h038, 32'h0000_0007);
			wr(12'h024, 32'h0000_0003);
			pm.pulse(1);
			rc(12'h038, (m == 3) ? 32'h0000_0000 : 32'h0000_0004, "capture");
		end
		// One-shot on channel 3: output flips at A, run ends at B
		wr(12'h06c, 32'h0000_0002);
		wr(12'h070, 32'h0000_0028);
		wr(12'h060, 32'h0000_0002);
		wr(12'h064, 32'h0000_0003);
		repeat (20) @(posedge clk);
		chk("one-shot pulse", 32'h0000_0001, cout[3]);
		repeat (100) @(posedge clk);
		chk("one-shot end", 32'h0000_0000, cout[3]);
		rc(12'h064, 32'h0000_0000, "one-shot run");
		rc(12'h078, 32'h0000_0006, "one-shot flags");
		// Decoder mode is set before its interrupt is enabled
		wr(12'h140, 32'h0000_0001);
		wr(12'h01c, 32'h0000_0200);
		wr(12'h004, 32'h0000_0003);
		pm.quad(1'b1);
		rd(12'h018, rd_d, rd_r);
		chk("forward", 32'h0000_0000, rd_d[10:9]);
		rc(12'h014, 32'h0000_0001, "phase a count");
		// Both A edges, counted down while B leads
		wr(12'h140, 32'h0000_0121);
		pm.quad(1'b0);
		pm.quad(1'b0);
		rd(12'h018, rd_d, rd_r);
		chk("reverse", 32'h0000_0003, rd_d[10:9]);
		chk("dir irq", 32'h0000_0001, irq[0]);
		rc(12'h014, 32'h0000_fffd, "phase a down");
		test_done;
	end
endmodule
